// ==== dv/bus_controller_model.sv ====
// behavioural remote bus controller issuing mask writes, queries and polls
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model (
  // clock
  input wire logic clk,
  // command strobes toward the device
  output logic maskWrite,
  output logic [7:0] maskWdata,
  output logic statusQuery,
  output logic maskQuery,
  output logic serialPoll
);
  // ==========================================================
  // idle state at time zero
  initial begin
    maskWrite = 1'b0;
    maskWdata = 8'h00;
    statusQuery = 1'b0;
    maskQuery = 1'b0;
    serialPoll = 1'b0;
  end

  // ==========================================================
  // one command: 0 write, 1 status query, 2 mask query, 3 poll
  task automatic issue(input int kind, input logic [7:0] v);
    @(negedge clk);
    maskWrite = (kind == 0);
    maskWdata = v;  // eight bits, so only 0..255 can be sent
    statusQuery = (kind == 1);
    maskQuery = (kind == 2);
    serialPoll = (kind == 3);
    @(negedge clk);
    maskWrite = 1'b0;
    statusQuery = 1'b0;
    maskQuery = 1'b0;
    serialPoll = 1'b0;
    // released data shows no stale value, so a late capture is caught
    maskWdata = ~v;
  endtask
endmodule
`default_nettype wire

// ==== dv/status_byte_service_request_tb_top.sv ====
// self-checking bench for the status byte and service request block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module status_byte_service_request_tb_top;
  import status_byte_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic gpibRemote = 1'b0;
  sources_s sources = '0;
  logic maskWrite, statusQuery, maskQuery, serialPoll, serviceRequest, pollValid, answerValid;
  logic [7:0] maskWdata, statusByte, serviceMask, pollByte, mask, sb;
  decimal_s answer;
  int fails = 0;
  int nChecks = 0;
  int seed = 32'h1d92040a;

  // ==========================================================
  // expectations worked out from the status byte layout
  function automatic logic [7:0] expStatus(sources_s s, logic [7:0] m);
    logic [7:0] b;
    b = 8'h00;
    b[5] = |(s.stdEvent & s.stdEventEnable);
    b[4] = s.msgAvailable;
    b[1] = s.localBusExecError;
    b[0] = s.localBusTimeout;
    // bit 6 of the mask never counts, avoiding self feedback
    b[6] = |(b & m & 8'h33);
    return b;
  endfunction

  function automatic decimal_s dec(logic [7:0] v);
    dec.hundreds = 4'(v / 8'h64);
    dec.tens = 4'((v / 8'h0a) % 8'h0a);
    dec.ones = 4'(v % 8'h0a);
    dec.len = (v >= 8'h64) ? 2'h3 : ((v >= 8'h0a) ? 2'h2 : 2'h1);
  endfunction

  // ==========================================================
  // clock, instances, verdict
  initial begin
    forever #12.5 clk = ~clk;
  end

  status_byte_service_request i_status_byte_service_request (.clk(clk), .reset(reset), .ce(ce),
    .sources(sources), .gpibRemote(gpibRemote), .maskWrite(maskWrite), .maskWdata(maskWdata),
    .statusQuery(statusQuery), .maskQuery(maskQuery), .serialPoll(serialPoll),
    .statusByte(statusByte), .serviceMask(serviceMask), .serviceRequest(serviceRequest),
    .pollByte(pollByte), .pollValid(pollValid), .answer(answer), .answerValid(answerValid));

  bus_controller_model i_bus_controller_model (.clk(clk), .maskWrite(maskWrite),
    .maskWdata(maskWdata), .statusQuery(statusQuery), .maskQuery(maskQuery), .serialPoll(serialPoll));

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the sequence needs about 570 cycles
  initial begin
    #(25 * 5000);
    fails++;
    endOfTest();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    `CHK(statusByte, 8'h00)
    `CHK(serviceMask, 8'h00)
    // random sources and masks, with all-ones and all-zeros masks first
    for (int i = 0; i < 60; i++) begin
      sources = sources_s'($random(seed));
      mask = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'($random(seed)));
      i_bus_controller_model.issue(0, mask);
      repeat (3) @(negedge clk);
      sb = expStatus(sources, mask);
      `CHK(statusByte, sb)
      `CHK(serviceMask, mask)
      i_bus_controller_model.issue(1, 8'h00);
      `CHK(answerValid, 1'b1)
      `CHK(answer, dec(sb))
      `CHK(statusByte, sb)
      i_bus_controller_model.issue(2, 8'h00);
      `CHK(answer, dec(mask))
    end
    // request flag: rise, interface gating, poll clear, summary clear
    sources = '0;
    gpibRemote = 1'b1;
    i_bus_controller_model.issue(0, 8'h10);
    repeat (3) @(negedge clk);
    `CHK(serviceRequest, 1'b0)
    sources.msgAvailable = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(serviceRequest, 1'b1)
    `CHK(statusByte, 8'h50)
    gpibRemote = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(serviceRequest, 1'b0)
    gpibRemote = 1'b1;
    i_bus_controller_model.issue(3, 8'h00);
    `CHK(pollValid, 1'b1)
    `CHK(pollByte, 8'h50)
    @(negedge clk);
    `CHK(serviceRequest, 1'b0)
    `CHK(statusByte, 8'h50)
    // a second poll sees the cleared flag although the summary still stands
    i_bus_controller_model.issue(3, 8'h00);
    `CHK(pollByte, 8'h10)
    sources.msgAvailable = 1'b0;
    repeat (3) @(negedge clk);
    sources.msgAvailable = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(serviceRequest, 1'b1)
    sources.msgAvailable = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(serviceRequest, 1'b0)
    `CHK(statusByte, 8'h00)
    // a frozen block ignores a write; the mask persists
    ce = 1'b0;
    i_bus_controller_model.issue(0, 8'haa);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(serviceMask, 8'h10)
    // second reset clears the mask regardless of its old value
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    `CHK(serviceMask, 8'h00)
    endOfTest();
  end
endmodule
`undef CHK
`default_nettype wire

// ==== verilog/byte_to_decimal.sv ====
// combinational byte to three-digit decimal converter with length
`timescale 1ns/1ps
`default_nettype none
module byte_to_decimal
  import status_byte_pkg::*;
(
  // binary value in
  input wire logic [7:0] value,
  // decimal digits out
  output decimal_s digits
);

  // ==========================================================
  // digit extraction by constant division, small enough for 8 bits
  logic [7:0] hundredsFull;  // value / 100
  logic [7:0] tensFull;  // (value / 10) % 10
  logic [7:0] onesFull;  // value % 10
  logic [1:0] lenSel;  // digits to send

  assign hundredsFull = value / DEC_HUNDRED;
  assign tensFull = (value / DEC_TEN) % DEC_TEN;
  assign onesFull = value % DEC_TEN;

  // leading zeros are suppressed so zero still sends one digit
  assign lenSel = (value >= DEC_HUNDRED) ? LEN_THREE : (value >= DEC_TEN) ? LEN_TWO : LEN_ONE;
  // one driver for the whole carrier, fields in declaration order
  assign digits = {hundredsFull[3:0], tensFull[3:0], onesFull[3:0], lenSel};

endmodule
`default_nettype wire

// ==== verilog/status_byte_pkg.sv ====
// shared constants and carriers for the status byte and service request logic
package status_byte_pkg;

  // ==========================================================
  // widths and reset values
  localparam int BYTE_W = 8;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ==========================================================
  // status byte bit positions
  localparam int BIT_TIMEOUT = 0;  // local bus timeout
  localparam int BIT_EXEC_ERR = 1;  // local bus execution error
  localparam int BIT_MAV = 4;  // output message available
  localparam int BIT_ESB = 5;  // standard event summary
  localparam int BIT_MSS = 6;  // master summary / request for service
  // enabled summary sources: bits 5,4,1,0; unused 7,3,2 and the summary bit itself excluded
  localparam logic [7:0] SUMMARY_SRC = 8'h33;

  // ==========================================================
  // decimal formatting constants
  localparam logic [7:0] DEC_TEN = 8'h0a;
  localparam logic [7:0] DEC_HUNDRED = 8'h64;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] hundreds;  // bcd digit, most significant
    logic [3:0] tens;  // bcd digit
    logic [3:0] ones;  // bcd digit, least significant
    logic [1:0] len;  // digits to send, leading zeros suppressed
  } decimal_s;

  typedef struct packed {
    logic [7:0] stdEvent;  // standard event register contents
    logic [7:0] stdEventEnable;  // standard event enable contents
    logic msgAvailable;  // output queue holds at least one message
    logic localBusExecError;  // local bus execution error level
    logic localBusTimeout;  // local bus timeout level
  } sources_s;

endpackage

// ==== verilog/status_byte_service_request.sv ====
// status byte, service request mask and request-for-service logic
`timescale 1ns/1ps
`default_nettype none
module status_byte_service_request
  import status_byte_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // status sources from the event register and output queue
  input wire sources_s sources,
  // remote interface selection
  input wire logic gpibRemote,
  // decoded commands from the parser, one-cycle pulses
  input wire logic maskWrite,
  input wire logic [7:0] maskWdata,
  input wire logic statusQuery,
  input wire logic maskQuery,
  input wire logic serialPoll,
  // register views
  output logic [7:0] statusByte,
  output logic [7:0] serviceMask,
  // service request line level and serial poll answer
  output logic serviceRequest,
  output logic [7:0] pollByte,
  output logic pollValid,
  // decimal query answer
  output decimal_s answer,
  output logic answerValid
);

  // ==========================================================
  // state registers
  logic [7:0] statusByte_r;  // status byte, summary in bit 6
  logic [7:0] statusByte_nxt;
  logic [7:0] maskByte_r;  // service request mask
  logic [7:0] maskByte_nxt;
  logic rqs_r;  // request-for-service flag
  logic rqs_nxt;
  logic serviceRequest_r;  // registered line level
  logic [7:0] pollByte_r;  // byte captured at serial poll
  logic pollValid_r;
  decimal_s answer_r;  // formatted query answer
  logic answerValid_r;

  // ==========================================================
  // status byte assembly
  logic esbNxt;  // standard event summary
  logic mssNxt;  // master summary
  logic [7:0] srcBits;  // status bits without summary
  logic [7:0] maskEff;  // mask gated to live sources

  assign esbNxt = |(sources.stdEvent & sources.stdEventEnable);
  assign srcBits = {1'b0, 1'b0, esbNxt, sources.msgAvailable, 1'b0, 1'b0, sources.localBusExecError,
    sources.localBusTimeout};
  // unused positions and the summary bit never feed the summary, avoiding self-latching
  assign maskEff = maskByte_r & SUMMARY_SRC;
  assign mssNxt = |(srcBits & maskEff);
  assign statusByte_nxt = srcBits | ({7'h00, mssNxt} << BIT_MSS);

  // ==========================================================
  // request flag: set on rising summary, cleared by low summary or poll
  logic mssRise;  // summary goes from zero to one
  assign mssRise = mssNxt & ~statusByte_r[BIT_MSS];
  // a rise in the poll cycle wins over the poll clear so no request is lost
  assign rqs_nxt = mssRise ? 1'b1 : (!mssNxt || serialPoll) ? 1'b0 : rqs_r;

  // ==========================================================
  // mask write path, any byte value accepted
  assign maskByte_nxt = maskWrite ? maskWdata : maskByte_r;

  // ==========================================================
  // answer selection, status query wins if both arrive together
  logic [7:0] answerSrc;  // byte to format
  logic anyQuery;
  decimal_s answerDec;
  assign answerSrc = statusQuery ? statusByte_r : maskByte_r;
  assign anyQuery = statusQuery | maskQuery;

  byte_to_decimal formatter (
    .value(answerSrc),
    .digits(answerDec)
  );

  // ==========================================================
  // status, mask and request registers; power-up reset clears all
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      statusByte_r <= STATUS_RESET;
      maskByte_r <= MASK_RESET;
      rqs_r <= 1'b0;
      serviceRequest_r <= 1'b0;
    end else if (ce) begin
      statusByte_r <= statusByte_nxt;
      maskByte_r <= maskByte_nxt;
      rqs_r <= rqs_nxt;
      serviceRequest_r <= rqs_nxt & gpibRemote;
    end
  end

  // ==========================================================
  // serial poll capture: request flag in bit 6 replaces the summary
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pollByte_r <= STATUS_RESET;
      pollValid_r <= 1'b0;
    end else if (ce) begin
      pollValid_r <= serialPoll;
      if (serialPoll) begin
        pollByte_r <= (statusByte_r & ~(8'h01 << BIT_MSS)) | ({7'h00, rqs_r} << BIT_MSS);
      end
    end
  end

  // ==========================================================
  // query answers, formatted in decimal; reading clears nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      answer_r <= '0;
      answerValid_r <= 1'b0;
    end else if (ce) begin
      answerValid_r <= anyQuery;
      if (anyQuery) begin
        answer_r <= answerDec;
      end
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign statusByte = statusByte_r;
  assign serviceMask = maskByte_r;
  assign serviceRequest = serviceRequest_r;
  assign pollByte = pollByte_r;
  assign pollValid = pollValid_r;
  assign answer = answer_r;
  assign answerValid = answerValid_r;

  // ==========================================================
  // assertions
  unused_bits_zero_a: assert property (@(posedge clk) disable iff (reset)
    (statusByte_r[7] == 1'b0) && (statusByte_r[3] == 1'b0) && (statusByte_r[2] == 1'b0))
    else $error("unused status bits not zero");

  summary_masked_a: assert property (@(posedge clk) disable iff (reset)
    ce |=> statusByte_r[BIT_MSS] == |(statusByte_r & $past(maskByte_r) & SUMMARY_SRC))
    else $error("summary bit does not match masked status");

  request_rise_a: assert property (@(posedge clk) disable iff (reset)
    $past(ce) && $rose(statusByte_r[BIT_MSS]) |-> rqs_r)
    else $error("request flag not set on summary rise");

  request_low_clear_a: assert property (@(posedge clk) disable iff (reset)
    !statusByte_r[BIT_MSS] |-> !rqs_r)
    else $error("request flag set while summary low");

  poll_clears_request_a: assert property (@(posedge clk) disable iff (reset)
    ce && serialPoll && statusByte_r[BIT_MSS] |=> !rqs_r ##1 !rqs_r || $past(ce) && $past(statusByte_r[BIT_MSS]) == 1'b0)
    else $error("serial poll did not clear request flag");

  mask_store_a: assert property (@(posedge clk) disable iff (reset)
    ce && maskWrite |=> serviceMask == $past(maskWdata))
    else $error("mask write not stored");

  mask_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(ce && maskWrite) |=> $stable(maskByte_r))
    else $error("mask changed without a write");

  event_summary_a: assert property (@(posedge clk) disable iff (reset)
    ce |=> statusByte_r[BIT_ESB] == |($past(sources.stdEvent) & $past(sources.stdEventEnable)))
    else $error("event summary bit wrong");

  message_bit_a: assert property (@(posedge clk) disable iff (reset)
    ce |=> statusByte_r[BIT_MAV] == $past(sources.msgAvailable))
    else $error("message available bit wrong");

  // a frozen block keeps its line level, so only check after a running cycle
  gpib_only_a: assert property (@(posedge clk) disable iff (reset)
    serviceRequest && $past(ce) |-> rqs_r && $past(gpibRemote))
    else $error("service request outside GPIB");

  query_decimal_a: assert property (@(posedge clk) disable iff (reset)
    ce && statusQuery |=> answerValid &&
      (answer.hundreds * DEC_HUNDRED + answer.tens * DEC_TEN + answer.ones) == $past(statusByte_r))
    else $error("status query answer wrong");

  // the mask is answered only when no status query shares the cycle
  mask_query_a: assert property (@(posedge clk) disable iff (reset)
    ce && maskQuery && !statusQuery |=> answerValid &&
      (answer.hundreds * DEC_HUNDRED + answer.tens * DEC_TEN + answer.ones) == $past(maskByte_r))
    else $error("mask query answer wrong");

  poll_byte_a: assert property (@(posedge clk) disable iff (reset)
    ce && serialPoll |=> pollValid && pollByte[BIT_MSS] == $past(rqs_r) &&
      (pollByte & SUMMARY_SRC) == ($past(statusByte_r) & SUMMARY_SRC))
    else $error("serial poll byte wrong");

  mask_write_c: cover property (@(posedge clk) disable iff (reset) ce && maskWrite);
  request_rise_c: cover property (@(posedge clk) disable iff (reset) $rose(serviceRequest));
  poll_with_req_c: cover property (@(posedge clk) disable iff (reset) ce && serialPoll && rqs_r);
  status_query_c: cover property (@(posedge clk) disable iff (reset) ce && statusQuery);

endmodule
`default_nettype wire
